// ### rtl/ivi_defs.svh
`ifndef IVI_DEFS_SVH
`define IVI_DEFS_SVH

// first init word fields
`define IVI_W1_IC4        0
`define IVI_W1_SINGLE_DEVICE_FLAG       1
`define IVI_W1_ADI        2
`define IVI_W1_LEVEL_TRIGGER_FLAG       3
`define IVI_W1_INIT       4
`define IVI_ADDR4_FIELD   7:5
`define IVI_ADDR8_FIELD   7:6
// vector base and cascade fields
`define IVI_TYPE_FIELD    7:3
`define IVI_ID_FIELD      2:0
// mode options word fields
`define IVI_W4_UPM        0
`define IVI_W4_AUTO_END_OF_INTERRUPT_FLAG       1
`define IVI_W4_MS         2
`define IVI_W4_BUF        3
`define IVI_W4_SPECIAL_NESTING_FLAG       4
// operation word 3 fields
`define IVI_OCW3_SEL      3
`define IVI_OCW3_ESMM     6
`define IVI_OCW3_SMM      5
`define IVI_OCW3_RR       1
`define IVI_OCW3_RIS      0
// acknowledge sequence
`define IVI_CALL_OPCODE   8'hcd
`define IVI_ACK_FIRST     2'h0
`define IVI_ACK_SECOND    2'h1
`define IVI_ACK_THIRD     2'h2
`define IVI_PAD4          2'h0
`define IVI_PAD8          3'h0
`define IVI_LEVEL_DEFAULT 3'h7
`define IVI_LEVEL_ZERO    3'h0
`define IVI_EDGE_RESET    8'hff
`define IVI_ZERO8         8'h00
`define IVI_ONE8          8'h01
`define IVI_ACKS_CALL     2'h3
`define IVI_ACKS_VECTOR   2'h2
// host register offsets
`define IVI_HR_BUS_WR_LO  4'h0
`define IVI_HR_BUS_WR_HI  4'h1
`define IVI_HR_ACK_SEQ    4'h2
`define IVI_HR_BUS_RD     4'h3
`define IVI_HR_ACK_BYTE0  4'h4
`define IVI_HR_ACK_BYTE1  4'h5
`define IVI_HR_ACK_BYTE2  4'h6
`define IVI_HR_STATUS     4'h7
`define IVI_ST_INT        0
`define IVI_ST_BUSY       1

`endif

// ### rtl/ivi_pkg.sv
package ivi_pkg;

    typedef enum logic [2:0] {
        IVI_UNINIT,
        IVI_WAIT_VEC,
        IVI_WAIT_CAS,
        IVI_WAIT_OPT,
        IVI_READY
    } ivi_init_state_type;

    typedef logic [7:0] ivi_byte_type;

endpackage

// ### rtl/ivi_bus_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ivi_bus_if;
    logic       wrStb;       // write strobe, one cycle
    logic       rdStb;       // status read strobe, one cycle
    logic       addrSel;     // address select input
    logic [7:0] dataToDev;   // write data
    logic [7:0] dataFromDev; // device data bus out
    logic       dataOe;      // device drives its data bus
    logic       intAck;      // int_ack_pulse, one cycle
    logic       intReq;      // interrupt request to processor

    modport devEnd (
        input  wrStb, rdStb, addrSel, dataToDev, intAck,
        output dataFromDev, dataOe, intReq
    );

    modport hostEnd (
        output wrStb, rdStb, addrSel, dataToDev, intAck,
        input  dataFromDev, dataOe, intReq
    );
endinterface

`default_nettype wire

// ### rtl/ivi_prio_pick.sv
`timescale 1ns/10ps
`default_nettype none
`include "ivi_defs.svh"

// finds the lowest set index, index 0 being the highest priority
module ivi_prio_pick (
    input  wire logic [7:0] bits,  // candidate bits
    output logic            found, // any bit set
    output logic [2:0]      level  // index of the winning bit
);
    always_comb begin
        found = 1'b0;
        level = `IVI_LEVEL_ZERO;
        for (int i = 7; i >= 0; i--) begin
            if (bits[i]) begin
                found = 1'b1;
                level = 3'(i);
            end
        end
    end
endmodule // ivi_prio_pick

`default_nettype wire

// ### rtl/ivi_device_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "ivi_defs.svh"

// Summary of operation
// - call mode: three acks, opcode first
// - interval four: address 7..5, level 4..2
// - interval eight: address 7..6, level 5..3
// - third ack sends vector base byte
// - vector mode: two acks, first freezes, no data
// - vector byte: type bits over level
// - select low, bit four high starts init
// - software writes two to four init bytes
// - first word resets edge sense
// - first word clears mask, fixed priority
// - first word clears special mask, reads pending
// - no fourth word zeroes mode options
// - level trigger flag disables edge detect
// - interval select: one four, zero eight
// - cascaded: third word loads slave register
// - master sends first byte, slave rest
// - slave matches cascade id, drives bytes
// - buffered: pin becomes enable, role bit
// - buffered role bit one master, zero slave
// - special nesting flag selects special nesting in a master
// - auto end flag clears service at end
// - processor mode bit picks ack protocol
// - first ack sets service, clears pending
// - no request answers as level seven
module ivi_device_end (
    input  wire logic       ref_clk,      // 100 MHz clock
    input  wire logic       sys_rst,      // synchronous reset, high
    ivi_bus_if.devEnd       bus,          // processor side
    input  wire logic [7:0] requestInput, // request_input lines
    input  wire logic [2:0] casIn,        // cascade_lines in
    output logic [2:0]      casOut,       // cascade_lines out
    output logic            casOe,        // cascade_lines enable
    input  wire logic       spIn,         // slave program level in
    output logic            spOut,        // buffer enable level out
    output logic            spOe          // slave program pin enable
);
    import ivi_pkg::*;

    ivi_init_state_type initState;
    ivi_byte_type       initFirst;
    ivi_byte_type       vectorBase;
    ivi_byte_type       cascadeMap;
    ivi_byte_type       modeOptions;
    ivi_byte_type       maskReg;
    ivi_byte_type       pendingReg;
    ivi_byte_type       inServiceReg;
    ivi_byte_type       prevReq;
    ivi_byte_type       next_pending;
    ivi_byte_type       next_data;
    logic               next_oe;
    logic               specialMask;
    logic               readInService;
    logic [1:0]         ackIdx;
    logic [1:0]         lastIdx;
    logic [2:0]         ackLevel;
    logic [2:0]         reqLevel;
    logic [2:0]         srvLevel;
    logic               reqFound;
    logic               srvFound;

    wire logic wrLow     = bus.wrStb & ~bus.addrSel;
    wire logic wrHigh    = bus.wrStb & bus.addrSel;
    wire logic initStart = wrLow & bus.dataToDev[`IVI_W1_INIT];
    wire logic ready     = (initState == IVI_READY);
    wire logic levelMode = initFirst[`IVI_W1_LEVEL_TRIGGER_FLAG];
    wire logic cascaded  = ~initFirst[`IVI_W1_SINGLE_DEVICE_FLAG];
    wire logic vecMode   = modeOptions[`IVI_W4_UPM];
    wire logic buffered  = modeOptions[`IVI_W4_BUF];
    // role comes from the role bit only when buffered
    wire logic isMaster  = buffered ? modeOptions[`IVI_W4_MS] : spIn;
    wire logic firstAck  = bus.intAck & (ackIdx == `IVI_ACK_FIRST);
    wire logic lastAck   = bus.intAck & (ackIdx == lastIdx);
    wire logic casMatch  = (casIn == cascadeMap[`IVI_ID_FIELD]);
    wire logic [2:0] freezeLevel = reqFound ? reqLevel
                                            : `IVI_LEVEL_DEFAULT;
    // a slave answers later bytes only when its id is on the lines
    wire logic driveLater = ~cascaded |
                            (isMaster ? ~cascadeMap[ackLevel]
                                      : casMatch);

    assign lastIdx = vecMode ? `IVI_ACK_SECOND : `IVI_ACK_THIRD;

    ivi_prio_pick u_pickReq (
        .bits  (pendingReg & ~maskReg),
        .found (reqFound),
        .level (reqLevel)
    );

    ivi_prio_pick u_pickSrv (
        .bits  (specialMask ? (inServiceReg & ~maskReg) : inServiceReg),
        .found (srvFound),
        .level (srvLevel)
    );

    // initialization word sequence
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            initState   <= IVI_UNINIT;
            initFirst   <= `IVI_ZERO8;
            vectorBase  <= `IVI_ZERO8;
            cascadeMap  <= `IVI_ZERO8;
            modeOptions <= `IVI_ZERO8;
        end else if (initStart) begin
            initFirst <= bus.dataToDev;
            initState <= IVI_WAIT_VEC;
            if (!bus.dataToDev[`IVI_W1_IC4]) begin
                modeOptions <= `IVI_ZERO8;
            end
        end else if (wrHigh) begin
            unique case (initState)
                IVI_WAIT_VEC: begin
                    vectorBase <= bus.dataToDev;
                    if (cascaded) begin
                        initState <= IVI_WAIT_CAS;
                    end else if (initFirst[`IVI_W1_IC4]) begin
                        initState <= IVI_WAIT_OPT;
                    end else begin
                        initState <= IVI_READY;
                    end
                end
                IVI_WAIT_CAS: begin
                    cascadeMap <= bus.dataToDev;
                    if (initFirst[`IVI_W1_IC4]) begin
                        initState <= IVI_WAIT_OPT;
                    end else begin
                        initState <= IVI_READY;
                    end
                end
                IVI_WAIT_OPT: begin
                    modeOptions <= bus.dataToDev;
                    initState   <= IVI_READY;
                end
                IVI_UNINIT, IVI_READY: begin
                end
            endcase
        end
    end

    // mask register, written by a high-select write once ready
    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            maskReg <= `IVI_ZERO8;
        end else if (wrHigh && ready) begin
            maskReg <= bus.dataToDev;
        end
    end

    // special mask and read source from operation word 3
    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            specialMask   <= 1'b0;
            readInService <= 1'b0;
        end else if (wrLow && ready && bus.dataToDev[`IVI_OCW3_SEL]) begin
            if (bus.dataToDev[`IVI_OCW3_ESMM]) begin
                specialMask <= bus.dataToDev[`IVI_OCW3_SMM];
            end
            if (bus.dataToDev[`IVI_OCW3_RR]) begin
                readInService <= bus.dataToDev[`IVI_OCW3_RIS];
            end
        end
    end

    // all-ones history means an input held high needs a fresh rise
    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            prevReq <= `IVI_EDGE_RESET;
        end else begin
            prevReq <= requestInput;
        end
    end

    always_comb begin
        if (levelMode) begin
            next_pending = requestInput;
        end else begin
            next_pending = (pendingReg | (requestInput & ~prevReq))
                         & requestInput;
        end
        if (firstAck && reqFound) begin
            next_pending[reqLevel] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            pendingReg <= `IVI_ZERO8;
        end else begin
            pendingReg <= next_pending;
        end
    end

    // in-service bits: set on first ack, auto cleared on the last
    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            inServiceReg <= `IVI_ZERO8;
        end else if (firstAck && reqFound) begin
            inServiceReg[reqLevel] <= 1'b1;
        end else if (lastAck && modeOptions[`IVI_W4_AUTO_END_OF_INTERRUPT_FLAG]) begin
            inServiceReg[ackLevel] <= 1'b0;
        end
    end

    // acknowledge counter and frozen level
    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            ackIdx   <= `IVI_ACK_FIRST;
            ackLevel <= `IVI_LEVEL_DEFAULT;
        end else if (bus.intAck) begin
            ackIdx <= lastAck ? `IVI_ACK_FIRST : 2'(ackIdx + 2'h1);
            if (firstAck) begin
                ackLevel <= freezeLevel;
            end
        end
    end

    // equal level may interrupt again only under special nesting
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus.intReq <= 1'b0;
        end else begin
            bus.intReq <= ready && reqFound && (ackIdx == `IVI_ACK_FIRST) &&
                          (!srvFound || (reqLevel < srvLevel) ||
                           (modeOptions[`IVI_W4_SPECIAL_NESTING_FLAG] && isMaster &&
                            (reqLevel == srvLevel)));
        end
    end

    // cascade code from the end of the first ack to the last
    always_ff @(posedge ref_clk) begin
        if (sys_rst || initStart) begin
            casOut <= `IVI_LEVEL_ZERO;
            casOe  <= 1'b0;
        end else begin
            casOe <= cascaded & isMaster;
            if (firstAck && cascaded && isMaster &&
                cascadeMap[freezeLevel]) begin
                casOut <= freezeLevel;
            end else if (lastAck || firstAck) begin
                casOut <= `IVI_LEVEL_ZERO;
            end
        end
    end

    always_comb begin
        next_oe   = 1'b0;
        next_data = `IVI_ZERO8;
        if (bus.intAck) begin
            unique case (ackIdx)
                `IVI_ACK_FIRST: begin
                    next_oe   = ~vecMode & (~cascaded | isMaster);
                    next_data = `IVI_CALL_OPCODE;
                end
                `IVI_ACK_SECOND: begin
                    next_oe = driveLater;
                    if (vecMode) begin
                        next_data = {vectorBase[`IVI_TYPE_FIELD],
                                     ackLevel};
                    end else if (initFirst[`IVI_W1_ADI]) begin
                        next_data = {initFirst[`IVI_ADDR4_FIELD], ackLevel,
                                     `IVI_PAD4};
                    end else begin
                        next_data = {initFirst[`IVI_ADDR8_FIELD], ackLevel,
                                     `IVI_PAD8};
                    end
                end
                `IVI_ACK_THIRD: begin
                    next_oe   = driveLater;
                    next_data = vectorBase;
                end
                default: begin
                end
            endcase
        end else if (bus.rdStb) begin
            next_oe = 1'b1;
            if (bus.addrSel) begin
                next_data = maskReg;
            end else if (readInService) begin
                next_data = inServiceReg;
            end else begin
                next_data = pendingReg;
            end
        end
    end

    // data bus and buffer enable
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus.dataOe      <= 1'b0;
            bus.dataFromDev <= `IVI_ZERO8;
            spOut           <= 1'b0;
            spOe            <= 1'b0;
        end else begin
            bus.dataOe      <= next_oe;
            bus.dataFromDev <= next_data;
            spOut           <= buffered & next_oe;
            spOe            <= buffered;
        end
    end
endmodule // ivi_device_end

`default_nettype wire

// ### rtl/ivi_host_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "ivi_defs.svh"

module ivi_host_end (
    input  wire logic       ref_clk,  // 100 MHz clock
    input  wire logic       sys_rst,  // synchronous reset, high
    ivi_bus_if.hostEnd      bus,      // device side
    input  wire logic [3:0] swAddr,   // register offset
    input  wire logic [7:0] swWrData, // register write data
    input  wire logic       swWr,     // write strobe
    input  wire logic       swRd,     // read strobe
    output logic [7:0]      swRdData  // read data, cycle after swRd
);
    import ivi_pkg::*;

    ivi_byte_type ackBytes [3];
    ivi_byte_type readByte;
    logic [1:0]   ackLeft;
    logic [1:0]   ackPos;
    logic         ackCapture;
    logic         rdCapture;

    wire logic busy = (ackLeft != 2'h0) | bus.intAck | ackCapture;

    // write and read strobes towards the device; init order is software's
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus.wrStb     <= 1'b0;
            bus.rdStb     <= 1'b0;
            bus.addrSel   <= 1'b0;
            bus.dataToDev <= `IVI_ZERO8;
        end else begin
            bus.wrStb <= swWr && ((swAddr == `IVI_HR_BUS_WR_LO) ||
                                  (swAddr == `IVI_HR_BUS_WR_HI));
            bus.rdStb <= swWr && (swAddr == `IVI_HR_BUS_RD);
            if (swWr && (swAddr == `IVI_HR_BUS_WR_LO)) begin
                bus.addrSel   <= 1'b0;
                bus.dataToDev <= swWrData;
            end else if (swWr && (swAddr == `IVI_HR_BUS_WR_HI)) begin
                bus.addrSel   <= 1'b1;
                bus.dataToDev <= swWrData;
            end else if (swWr && (swAddr == `IVI_HR_BUS_RD)) begin
                bus.addrSel <= swWrData[0];
            end
        end
    end

    // ack sequence: pulse, gap, pulse; bit 0 of the order picks two
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ackLeft    <= 2'h0;
            bus.intAck <= 1'b0;
        end else if (swWr && (swAddr == `IVI_HR_ACK_SEQ) && !busy) begin
            ackLeft    <= swWrData[0] ? `IVI_ACKS_VECTOR
                                      : `IVI_ACKS_CALL;
            bus.intAck <= 1'b0;
        end else if ((ackLeft != 2'h0) && !bus.intAck) begin
            ackLeft    <= 2'(ackLeft - 2'h1);
            bus.intAck <= 1'b1;
        end else begin
            bus.intAck <= 1'b0;
        end
    end

    // capture the byte that answers each pulse
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ackCapture <= 1'b0;
            rdCapture  <= 1'b0;
            ackPos     <= 2'h0;
            readByte   <= `IVI_ZERO8;
            for (int i = 0; i < 3; i++) begin
                ackBytes[i] <= `IVI_ZERO8;
            end
        end else begin
            ackCapture <= bus.intAck;
            rdCapture  <= bus.rdStb;
            if (swWr && (swAddr == `IVI_HR_ACK_SEQ) && !busy) begin
                ackPos <= 2'h0;
                for (int i = 0; i < 3; i++) begin
                    ackBytes[i] <= `IVI_ZERO8;
                end
            end else if (ackCapture) begin
                ackBytes[ackPos] <= bus.dataOe ? bus.dataFromDev
                                               : `IVI_ZERO8;
                ackPos           <= 2'(ackPos + 2'h1);
            end
            if (rdCapture) begin
                readByte <= bus.dataOe ? bus.dataFromDev : `IVI_ZERO8;
            end
        end
    end

    // register read port
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !swRd) begin
            swRdData <= `IVI_ZERO8;
        end else begin
            unique case (swAddr)
                `IVI_HR_ACK_BYTE0: swRdData <= ackBytes[0];
                `IVI_HR_ACK_BYTE1: swRdData <= ackBytes[1];
                `IVI_HR_ACK_BYTE2: swRdData <= ackBytes[2];
                `IVI_HR_BUS_RD:    swRdData <= readByte;
                `IVI_HR_STATUS: begin
                    swRdData                <= `IVI_ZERO8;
                    swRdData[`IVI_ST_INT]   <= bus.intReq;
                    swRdData[`IVI_ST_BUSY]  <= busy;
                end
                default:           swRdData <= `IVI_ZERO8;
            endcase
        end
    end
endmodule // ivi_host_end

`default_nettype wire

// ### verif/ivi_bus_sva.sv
`timescale 1ns/10ps
`default_nettype none

module ivi_bus_sva (
    input wire logic       ref_clk,     // clock
    input wire logic       sys_rst,     // synchronous reset
    input wire logic       wrStb,       // write strobe
    input wire logic       rdStb,       // status read strobe
    input wire logic       addrSel,     // address select
    input wire logic [7:0] dataToDev,   // write data
    input wire logic [7:0] dataFromDev, // device data
    input wire logic       dataOe,      // device drives data
    input wire logic       intAck,      // acknowledge pulse
    input wire logic       intReq       // interrupt request
);
    logic [7:0] w1;
    logic [7:0] base;
    logic [1:0] idx;
    logic [1:0] ackCnt;
    logic       vecMode;
    wire        first = wrStb && !addrSel && dataToDev[4];
    wire        optWr = wrStb && addrSel && w1[0] &&
                        idx == (w1[1] ? 2'h1 : 2'h2);

    // shadow of the init sequence and of the ack position
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            idx     <= 2'h0;
            vecMode <= 1'b0;
            ackCnt  <= 2'h0;
        end else if (first) begin
            w1      <= dataToDev;
            idx     <= 2'h0;
            vecMode <= 1'b0;
            ackCnt  <= 2'h0;
        end else begin
            if (wrStb && addrSel && idx == 2'h0)
                base <= dataToDev;
            if (wrStb && addrSel && idx != 2'h3)
                idx <= idx + 2'h1;
            if (optWr)
                vecMode <= dataToDev[0];
            if (intAck)
                ackCnt <= (ackCnt == {~vecMode, vecMode}) ? 2'h0
                                                          : ackCnt + 2'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_ack(logic v, logic [1:0] n);
        intAck && vecMode == v && ackCnt == n;
    endsequence

    a_oe_has_cause: assert property (
        dataOe |-> $past(intAck) || $past(rdStb))
        else $error("data driven without a cause");
    a_oe_one_cycle: assert property (
        dataOe |=> !dataOe) else $error("data held too long");
    a_call_opcode: assert property (
        s_ack(1'b0, 2'h0) |=> dataOe && dataFromDev == 8'hcd)
        else $error("first call byte wrong");
    // a cascaded master leaves the later bytes to its slave
    a_call_low_addr: assert property (
        s_ack(1'b0, 2'h1) ##0 w1[1] |=> dataOe && (w1[2] ?
        dataFromDev[7:5] == w1[7:5] && dataFromDev[1:0] == 2'h0 :
        dataFromDev[7:6] == w1[7:6] && dataFromDev[2:0] == 3'h0))
        else $error("second call byte wrong");
    a_call_high_addr: assert property (
        s_ack(1'b0, 2'h2) ##0 w1[1] |=> dataOe && dataFromDev == base)
        else $error("third call byte wrong");
    a_vec_first_quiet: assert property (
        s_ack(1'b1, 2'h0) |=> !dataOe) else $error("first ack drove data");
    a_vec_type_byte: assert property (
        s_ack(1'b1, 2'h1) |=> dataOe && dataFromDev[7:3] == base[7:3])
        else $error("vector byte wrong");
    a_init_quiets_req: assert property (
        first |-> ##2 !intReq [*2]) else $error("request after init word");
    a_ack_drops_req: assert property (
        s_ack(vecMode, 2'h0) |-> ##2 !intReq)
        else $error("request held through ack");
endmodule // ivi_bus_sva

`default_nettype wire

// ### verif/interrupt_vector_and_init_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module interrupt_vector_and_init_tb_top;
    logic       ref_clk;
    logic       sys_rst;
    logic       swWr;
    logic       swRd;
    logic [3:0] swAddr;
    logic [7:0] swWrData;
    logic [7:0] swRdData;
    logic [7:0] reqIn;
    logic [7:0] rd;
    logic [2:0] casOut;
    logic       casOe;
    logic       spOe;
    int         miscompares = 0;
    int         checks = 0;

    ivi_bus_if bus ();
    ivi_device_end ivi_device_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .bus(bus), .requestInput(reqIn), .casIn(3'h0), .casOut(casOut),
        .casOe(casOe), .spIn(1'b1), .spOut(), .spOe(spOe));
    ivi_host_end ivi_host_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .bus(bus), .swAddr(swAddr), .swWrData(swWrData), .swWr(swWr),
        .swRd(swRd), .swRdData(swRdData));
    ivi_bus_sva ivi_bus_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .wrStb(bus.wrStb), .rdStb(bus.rdStb), .addrSel(bus.addrSel),
        .dataToDev(bus.dataToDev), .dataFromDev(bus.dataFromDev),
        .dataOe(bus.dataOe), .intAck(bus.intAck), .intReq(bus.intReq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        swAddr   <= a;
        swWrData <= d;
        swWr     <= 1'b1;
        @(posedge ref_clk);
        swWr     <= 1'b0;
    endtask

    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        swAddr <= a;
        swRd   <= 1'b1;
        @(posedge ref_clk);
        swRd   <= 1'b0;
        @(posedge ref_clk);
        d = swRdData;
    endtask

    // polls a status bit under a bounded count
    task automatic wait_st(input int b, input logic v);
        logic [7:0] s;
        int         n;
        n = 0;
        do begin
            sw_rd(4'h7, s);
            n++;
        end while (s[b] !== v && n < 40);
        if (s[b] !== v) begin
            miscompares++;
            $display("[FAIL] %0t status bit %0d stuck", $time, b);
            close_out();
        end
    endtask

    task automatic do_ack(input logic [7:0] m, input logic [7:0] e0,
                          input logic [7:0] e1, input logic [7:0] e2,
                          input logic [7:0] ec);
        sw_wr(4'h2, m);
        repeat (4) @(posedge ref_clk);
        chk({casOe, spOe, 3'h0, casOut}, ec);
        wait_st(1, 1'b0);
        sw_rd(4'h4, rd);
        chk(rd, e0);
        sw_rd(4'h5, rd);
        chk(rd, e1);
        sw_rd(4'h6, rd);
        chk(rd, e2);
    endtask

    task automatic t_vector();
        sw_wr(4'h0, 8'h13);
        sw_wr(4'h1, 8'ha8);
        sw_wr(4'h1, 8'h01);
        do_ack(8'h01, 8'h00, 8'haf, 8'h00, 8'h00);
        reqIn <= 8'h02;
        wait_st(0, 1'b1);
        do_ack(8'h01, 8'h00, 8'ha9, 8'h00,
               8'h00);
    endtask

    // line 1 stays high across the new init word
    task automatic t_call4();
        sw_wr(4'h0, 8'hb6);
        sw_wr(4'h1, 8'h5a);
        reqIn <= 8'h0a;
        wait_st(0, 1'b1);
        sw_wr(4'h3, 8'h00);
        repeat (4) @(posedge ref_clk);
        sw_rd(4'h3, rd);
        chk(rd, 8'h08);
        do_ack(8'h00, 8'hcd, 8'hac, 8'h5a,
               8'h00);
        sw_wr(4'h1, 8'hff);
    endtask

    task automatic t_call8();
        reqIn <= 8'h00;
        sw_wr(4'h0, 8'hd2);
        sw_wr(4'h1, 8'h33);
        sw_wr(4'h0, 8'h0a);
        reqIn <= 8'h20;
        wait_st(0, 1'b1);
        do_ack(8'h00, 8'hcd, 8'he8, 8'h33, 8'h00);
    endtask

    // buffered master leaves line 5 to its slave; then a level slave
    task automatic t_cascade();
        reqIn <= 8'h00;
        sw_wr(4'h0, 8'h15);
        sw_wr(4'h1, 8'h77);
        sw_wr(4'h1, 8'h20);
        sw_wr(4'h1, 8'h0c);
        reqIn <= 8'h20;
        wait_st(0, 1'b1);
        do_ack(8'h00, 8'hcd, 8'h00, 8'h00, 8'hc5);
        sw_wr(4'h0, 8'h1d);
        sw_wr(4'h1, 8'h77);
        sw_wr(4'h1, 8'h00);
        sw_wr(4'h1, 8'h09);
        wait_st(0, 1'b1);
        do_ack(8'h01, 8'h00, 8'h75, 8'h00, 8'h40);
    endtask

    initial begin
        sys_rst  <= 1'b1;
        swWr     <= 1'b0;
        swRd     <= 1'b0;
        swAddr   <= 4'h0;
        swWrData <= 8'h00;
        reqIn    <= 8'h00;
        repeat (5) @(posedge ref_clk);
        sys_rst  <= 1'b0;
        t_vector();
        t_call4();
        t_call8();
        t_cascade();
        close_out();
    end
endmodule // interrupt_vector_and_init_tb_top

`default_nettype wire
